// ---- rtl/gpbr_defines.vh ----
`ifndef GPBR_DEFINES_VH
`define GPBR_DEFINES_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define GPBR_BASE_ADDR      16'h5000
`define GPBR_PORT_STRIDE    5
`define GPBR_NUM_PORTS      6
`define GPBR_OFS_LATCH      3'h0
`define GPBR_OFS_PINVAL     3'h1
`define GPBR_OFS_DIR        3'h2
`define GPBR_OFS_CTL1       3'h3
`define GPBR_OFS_CTL2       3'h4
// Byte address of every port register
`define GPBR_ADDR_A_LATCH   16'h5000
`define GPBR_ADDR_A_PINVAL  16'h5001
`define GPBR_ADDR_A_DIR     16'h5002
`define GPBR_ADDR_A_CTL1    16'h5003
`define GPBR_ADDR_A_CTL2    16'h5004
`define GPBR_ADDR_B_LATCH   16'h5005
`define GPBR_ADDR_B_PINVAL  16'h5006
`define GPBR_ADDR_B_DIR     16'h5007
`define GPBR_ADDR_B_CTL1    16'h5008
`define GPBR_ADDR_B_CTL2    16'h5009
`define GPBR_ADDR_C_LATCH   16'h500a
`define GPBR_ADDR_C_PINVAL  16'h500b
`define GPBR_ADDR_C_DIR     16'h500c
`define GPBR_ADDR_C_CTL1    16'h500d
`define GPBR_ADDR_C_CTL2    16'h500e
`define GPBR_ADDR_D_LATCH   16'h500f
`define GPBR_ADDR_D_PINVAL  16'h5010
`define GPBR_ADDR_D_DIR     16'h5011
`define GPBR_ADDR_D_CTL1    16'h5012
`define GPBR_ADDR_D_CTL2    16'h5013
`define GPBR_ADDR_E_LATCH   16'h5014
`define GPBR_ADDR_E_PINVAL  16'h5015
`define GPBR_ADDR_E_DIR     16'h5016
`define GPBR_ADDR_E_CTL1    16'h5017
`define GPBR_ADDR_E_CTL2    16'h5018
`define GPBR_ADDR_F_LATCH   16'h5019
`define GPBR_ADDR_F_PINVAL  16'h501a
`define GPBR_ADDR_F_DIR     16'h501b
`define GPBR_ADDR_F_CTL1    16'h501c
`define GPBR_ADDR_F_CTL2    16'h501d
// Remap option bits register (coined offset, past the port block)
`define GPBR_REMAP_ADDR     16'h501e
// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPBR_RST_ZERO       8'h00
`define GPBR_RST_PD_CTL1    8'h02
// ----------------------------------------
// Port indices and line positions
// ----------------------------------------
`define GPBR_PORT_A         3'd0
`define GPBR_PORT_C         3'd2
`define GPBR_PORT_D         3'd3
`define GPBR_LINE_A1        1
`define GPBR_LINE_C6        6
`define GPBR_LINE_D1        1
`define GPBR_REMAP_C6_BIT   0
`endif

// ---- rtl/gpbr_port.v ----
`include "gpbr_defines.vh"
// One byte-wide port: latch, direction and two control registers, pad control.
module gpbr_port #(
    parameter [7:0] CTL1_RST = 8'h00,
    parameter [7:0] BONDED   = 8'hff
) (
    input  wire       clk,
    input  wire       rst_b,
    // Register writes from the decoder
    input  wire       wr_latch,
    input  wire       wr_dir,
    input  wire       wr_ctl1,
    input  wire       wr_ctl2,
    input  wire [7:0] wdata,
    // Halt override and alternate-function overlay
    input  wire [7:0] force_pu_in,
    input  wire [7:0] af_en,
    input  wire [7:0] af_out,
    // Stored state
    output reg  [7:0] latch_r,
    output reg  [7:0] dir_r,
    output reg  [7:0] ctl1_r,
    output reg  [7:0] ctl2_r,
    // Pad control
    output reg  [7:0] pad_out_r,
    output reg  [7:0] pad_oe_b_r,
    output reg  [7:0] pad_pu_r
);
    wire [7:0] drive_en;
    wire [7:0] drive_val;
    wire [7:0] od_release;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // Unbonded lines reset to input like the rest, floating unless CTL1_RST sets a pull-up
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latch_r <= `GPBR_RST_ZERO;
            dir_r   <= `GPBR_RST_ZERO;
            ctl1_r  <= CTL1_RST;
            ctl2_r  <= `GPBR_RST_ZERO;
        end
        else
        begin
            if (wr_latch) latch_r <= wdata;
            if (wr_dir)   dir_r   <= wdata;
            if (wr_ctl1)  ctl1_r  <= wdata;
            if (wr_ctl2)  ctl2_r  <= wdata;
        end
    end

    // ----------------------------------------
    // Pad driver
    // ----------------------------------------
    // Alternate functions overlay the value only; mode stays with the GPIO regs
    assign drive_val  = (af_en & af_out) | (~af_en & latch_r);
    // Open drain (control one low) only pulls low; a high is released
    assign od_release = ~ctl1_r & drive_val;
    assign drive_en   = dir_r & ~force_pu_in & ~od_release;

    // Registered so a latch write reaches the pin on the next edge
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pad_out_r  <= 8'h00;
            pad_oe_b_r <= 8'hff;
            pad_pu_r   <= CTL1_RST;
        end
        else
        begin
            pad_out_r  <= drive_val & drive_en;
            pad_oe_b_r <= ~drive_en;
            // Pull-up on inputs with control one set, or forced in halt
            pad_pu_r   <= ((~dir_r & ctl1_r) | force_pu_in) & BONDED;
        end
    end
endmodule // gpbr_port

// ---- rtl/gpbr_bank.v ----
// Function
// - Halt forces line A1 to pull-up input
// - Halt leaves line A1 output undriven
// - Line A1 gives no halt wakeup
// - Line D1 pull-up input at reset
// - Port D control one resets 0x02
// - Unbonded lines reset as floating inputs
// - Eight remap option bits exist
// - Remap disconnects the default alternate function
// - Alternate function needs peripheral enable
// - Remap leaves GPIO capability unchanged
// - Five registers per port, stride five
// - Pin value reads sampled pin levels
// - Floating/pull-up input, open-drain/push-pull output
//
// Chosen here: strobed register access.
`include "gpbr_defines.vh"
module gpbr_bank #(
    parameter NPORT = 6
) (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RST_B,
    // Register port
    input  wire [15:0] ADDR,
    input  wire [7:0]  WDATA,
    input  wire        WR_STB,
    input  wire        RD_STB,
    output reg  [7:0]  RDATA,
    // Low-power state
    input  wire        HALT_MODE,
    output wire        WAKE_REQ,
    input  wire [7:0]  WAKE_SRC_A,
    // Peripheral alternate-function sources
    input  wire        SPI_EN,
    input  wire        SPI_MOSI,
    input  wire        TIM1_EN,
    input  wire        ADVANCED_TIMER_CHANNEL_ONE,
    // Pads, six ports of eight lines, port A in the low byte
    input  wire [47:0] PAD_IN,
    output wire [47:0] PAD_OUT,
    output wire [47:0] PAD_OE_B,
    output wire [47:0] PAD_PU
);
    wire [47:0] latch_w;
    wire [47:0] dir_w;
    wire [47:0] ctl1_w;
    wire [47:0] ctl2_w;
    reg  [47:0] pinval_r;
    reg  [7:0]  remap_r;
    reg  [7:0]  rdata_nxt;
    reg  [2:0]  sel_port;
    reg  [2:0]  sel_reg;
    reg         sel_hit;
    wire [7:0]  force_a;
    wire [7:0]  af_en_c;
    wire [7:0]  af_out_c;
    wire        c6_af_en;
    wire        c6_af_val;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Ports are five bytes apart from the base
    // One flat case per byte address: longer than a divide by five, but
    // the map reads straight off the table and no arithmetic can overflow.
    // The remap register is decoded apart and so misses here on purpose.
    // Pin-value slots decode as hits; writes to them find no register.
    // Anything else reads zero and writes nowhere.
    always @*
    begin
        sel_port = 3'd0;
        sel_reg  = 3'd0;
        sel_hit  = 1'b1;
        case (ADDR)
            // Port A
            `GPBR_ADDR_A_LATCH:
            begin
                sel_port = 3'd0;
                sel_reg  = `GPBR_OFS_LATCH;
            end
            `GPBR_ADDR_A_PINVAL:
            begin
                sel_port = 3'd0;
                sel_reg  = `GPBR_OFS_PINVAL;
            end
            `GPBR_ADDR_A_DIR:
            begin
                sel_port = 3'd0;
                sel_reg  = `GPBR_OFS_DIR;
            end
            `GPBR_ADDR_A_CTL1:
            begin
                sel_port = 3'd0;
                sel_reg  = `GPBR_OFS_CTL1;
            end
            `GPBR_ADDR_A_CTL2:
            begin
                sel_port = 3'd0;
                sel_reg  = `GPBR_OFS_CTL2;
            end
            // Port B
            `GPBR_ADDR_B_LATCH:
            begin
                sel_port = 3'd1;
                sel_reg  = `GPBR_OFS_LATCH;
            end
            `GPBR_ADDR_B_PINVAL:
            begin
                sel_port = 3'd1;
                sel_reg  = `GPBR_OFS_PINVAL;
            end
            `GPBR_ADDR_B_DIR:
            begin
                sel_port = 3'd1;
                sel_reg  = `GPBR_OFS_DIR;
            end
            `GPBR_ADDR_B_CTL1:
            begin
                sel_port = 3'd1;
                sel_reg  = `GPBR_OFS_CTL1;
            end
            `GPBR_ADDR_B_CTL2:
            begin
                sel_port = 3'd1;
                sel_reg  = `GPBR_OFS_CTL2;
            end
            // Port C
            `GPBR_ADDR_C_LATCH:
            begin
                sel_port = 3'd2;
                sel_reg  = `GPBR_OFS_LATCH;
            end
            `GPBR_ADDR_C_PINVAL:
            begin
                sel_port = 3'd2;
                sel_reg  = `GPBR_OFS_PINVAL;
            end
            `GPBR_ADDR_C_DIR:
            begin
                sel_port = 3'd2;
                sel_reg  = `GPBR_OFS_DIR;
            end
            `GPBR_ADDR_C_CTL1:
            begin
                sel_port = 3'd2;
                sel_reg  = `GPBR_OFS_CTL1;
            end
            `GPBR_ADDR_C_CTL2:
            begin
                sel_port = 3'd2;
                sel_reg  = `GPBR_OFS_CTL2;
            end
            // Port D
            `GPBR_ADDR_D_LATCH:
            begin
                sel_port = 3'd3;
                sel_reg  = `GPBR_OFS_LATCH;
            end
            `GPBR_ADDR_D_PINVAL:
            begin
                sel_port = 3'd3;
                sel_reg  = `GPBR_OFS_PINVAL;
            end
            `GPBR_ADDR_D_DIR:
            begin
                sel_port = 3'd3;
                sel_reg  = `GPBR_OFS_DIR;
            end
            `GPBR_ADDR_D_CTL1:
            begin
                sel_port = 3'd3;
                sel_reg  = `GPBR_OFS_CTL1;
            end
            `GPBR_ADDR_D_CTL2:
            begin
                sel_port = 3'd3;
                sel_reg  = `GPBR_OFS_CTL2;
            end
            // Port E
            `GPBR_ADDR_E_LATCH:
            begin
                sel_port = 3'd4;
                sel_reg  = `GPBR_OFS_LATCH;
            end
            `GPBR_ADDR_E_PINVAL:
            begin
                sel_port = 3'd4;
                sel_reg  = `GPBR_OFS_PINVAL;
            end
            `GPBR_ADDR_E_DIR:
            begin
                sel_port = 3'd4;
                sel_reg  = `GPBR_OFS_DIR;
            end
            `GPBR_ADDR_E_CTL1:
            begin
                sel_port = 3'd4;
                sel_reg  = `GPBR_OFS_CTL1;
            end
            `GPBR_ADDR_E_CTL2:
            begin
                sel_port = 3'd4;
                sel_reg  = `GPBR_OFS_CTL2;
            end
            // Port F
            `GPBR_ADDR_F_LATCH:
            begin
                sel_port = 3'd5;
                sel_reg  = `GPBR_OFS_LATCH;
            end
            `GPBR_ADDR_F_PINVAL:
            begin
                sel_port = 3'd5;
                sel_reg  = `GPBR_OFS_PINVAL;
            end
            `GPBR_ADDR_F_DIR:
            begin
                sel_port = 3'd5;
                sel_reg  = `GPBR_OFS_DIR;
            end
            `GPBR_ADDR_F_CTL1:
            begin
                sel_port = 3'd5;
                sel_reg  = `GPBR_OFS_CTL1;
            end
            `GPBR_ADDR_F_CTL2:
            begin
                sel_port = 3'd5;
                sel_reg  = `GPBR_OFS_CTL2;
            end
            default:
                sel_hit = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Remap option bits
    // ----------------------------------------
    // Eight bits, software written here in place of option bytes
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
            remap_r <= `GPBR_RST_ZERO;
        else if (WR_STB && ADDR == `GPBR_REMAP_ADDR)
            remap_r <= WDATA;
    end

    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    // Pin value follows the pads one clock late; reset value is zero
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
            pinval_r <= 48'h0000_0000_0000;
        else
            pinval_r <= PAD_IN;
    end

    // ----------------------------------------
    // Alternate function on line C6
    // ----------------------------------------
    // Remap bit zero swaps MOSI for timer channel; default is then gone
    assign c6_af_en  = remap_r[`GPBR_REMAP_C6_BIT] ? TIM1_EN : SPI_EN;
    assign c6_af_val = remap_r[`GPBR_REMAP_C6_BIT] ? ADVANCED_TIMER_CHANNEL_ONE : SPI_MOSI;
    assign af_en_c   = {1'b0, c6_af_en, 6'b00_0000};
    assign af_out_c  = {1'b0, c6_af_val, 6'b00_0000};

    // Halt forces line A1 to pull-up input
    assign force_a   = {6'b00_0000, HALT_MODE, 1'b0};
    // Line A1 is masked out of wakeup while halted
    assign WAKE_REQ  = |(WAKE_SRC_A & ~force_a);

    // ----------------------------------------
    // Port instances
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPORT; g = g + 1)
        begin : g_port
            gpbr_port #(
                .CTL1_RST ((g == 3) ? `GPBR_RST_PD_CTL1 : `GPBR_RST_ZERO),
                .BONDED   (8'hff)
            ) u_port (
                .clk         (CORE_CLK),
                .rst_b       (RST_B),
                .wr_latch    (WR_STB && sel_hit && sel_port == g && sel_reg == `GPBR_OFS_LATCH),
                .wr_dir      (WR_STB && sel_hit && sel_port == g && sel_reg == `GPBR_OFS_DIR),
                .wr_ctl1     (WR_STB && sel_hit && sel_port == g && sel_reg == `GPBR_OFS_CTL1),
                .wr_ctl2     (WR_STB && sel_hit && sel_port == g && sel_reg == `GPBR_OFS_CTL2),
                .wdata       (WDATA),
                .force_pu_in ((g == 0) ? force_a : 8'h00),
                .af_en       ((g == 2) ? af_en_c : 8'h00),
                .af_out      ((g == 2) ? af_out_c : 8'h00),
                .latch_r     (latch_w[g*8 +: 8]),
                .dir_r       (dir_w[g*8 +: 8]),
                .ctl1_r      (ctl1_w[g*8 +: 8]),
                .ctl2_r      (ctl2_w[g*8 +: 8]),
                .pad_out_r   (PAD_OUT[g*8 +: 8]),
                .pad_oe_b_r  (PAD_OE_B[g*8 +: 8]),
                .pad_pu_r    (PAD_PU[g*8 +: 8])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Unmapped addresses read zero
    always @*
    begin
        rdata_nxt = 8'h00;
        if (ADDR == `GPBR_REMAP_ADDR)
            rdata_nxt = remap_r;
        else if (sel_hit)
        begin
            case (sel_reg)
                `GPBR_OFS_LATCH:  rdata_nxt = latch_w[sel_port*8 +: 8];
                `GPBR_OFS_PINVAL: rdata_nxt = pinval_r[sel_port*8 +: 8];
                `GPBR_OFS_DIR:    rdata_nxt = dir_w[sel_port*8 +: 8];
                `GPBR_OFS_CTL1:   rdata_nxt = ctl1_w[sel_port*8 +: 8];
                `GPBR_OFS_CTL2:   rdata_nxt = ctl2_w[sel_port*8 +: 8];
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    // Read data stand for the cycle after the strobe only
    always @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
            RDATA <= 8'h00;
        else if (RD_STB)
            RDATA <= rdata_nxt;
        else
            RDATA <= 8'h00;
    end
endmodule // gpbr_bank

// ---- tb/gpbr_bank_monitor.sv ----
// ----------------------------------------
// Port-side checks for the I/O bank
// ----------------------------------------
module gpbr_bank_monitor (
    // Clock and reset
    input logic        CORE_CLK,
    input logic        RST_B,
    // Register port
    input logic [15:0] ADDR,
    input logic        RD_STB,
    input logic [7:0]  RDATA,
    // Low-power state
    input logic        HALT_MODE,
    input logic        WAKE_REQ,
    input logic [7:0]  WAKE_SRC_A,
    // Pads
    input logic [47:0] PAD_IN,
    input logic [47:0] PAD_OUT,
    input logic [47:0] PAD_OE_B,
    input logic [47:0] PAD_PU
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    // Halt held for a while: line A1 pulled up and released
    property p_halt_pu; HALT_MODE [*3] |-> PAD_PU[1]; endproperty
    a_halt_pu: assert property (p_halt_pu) else $error("halt pull-up missing");
    property p_halt_oe; HALT_MODE [*3] |-> PAD_OE_B[1]; endproperty
    a_halt_oe: assert property (p_halt_oe) else $error("halt line driven");
    // Line A1 never wakes the core while halted
    property p_wake; WAKE_REQ == |(WAKE_SRC_A & ~{6'h00, HALT_MODE, 1'b0}); endproperty
    a_wake: assert property (p_wake) else $error("wake request wrong");
    // Fresh from reset: all lines released, only D1 pulled up
    property p_rst; $rose(RST_B) |-> PAD_OE_B == 48'hffff_ffff_ffff
        && PAD_PU == 48'h0000_0200_0000; endproperty
    a_rst: assert property (p_rst) else $error("reset pad state wrong");
    // Read data stands only in the cycle after a read strobe
    property p_rd_idle; !$past(RD_STB) |-> RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_unmapped; RD_STB && ADDR == 16'h6000 |=> RDATA == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Released lines show no drive value
    property p_od; (PAD_OUT & PAD_OE_B) == 48'h0000_0000_0000; endproperty
    a_od: assert property (p_od) else $error("value on released line");
    // Pin value of port A follows a steady pin level
    property p_pinval; RD_STB && ADDR == 16'h5001 && $stable(PAD_IN[7:0])
        |=> RDATA == $past(PAD_IN[7:0]); endproperty
    a_pinval: assert property (p_pinval) else $error("pin value read wrong");
    c_halt: cover property (HALT_MODE [*3]);
    c_pinval: cover property (RD_STB && ADDR == 16'h5001);
    c_rst: cover property ($rose(RST_B));
endmodule // gpbr_bank_monitor

bind gpbr_bank gpbr_bank_monitor gpbr_bank_monitor_inst (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
    .ADDR(ADDR), .RD_STB(RD_STB), .RDATA(RDATA), .HALT_MODE(HALT_MODE), .WAKE_REQ(WAKE_REQ),
    .WAKE_SRC_A(WAKE_SRC_A), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE_B(PAD_OE_B),
    .PAD_PU(PAD_PU));

// ---- tb/gpbr_pins.sv ----
// ----------------------------------------
// Board model: pins seen by the bank
// ----------------------------------------
module gpbr_pins (
    // Pad side of the bank
    input  logic [47:0] pad_out,
    input  logic [47:0] pad_oe_b,
    input  logic [47:0] pad_pu,
    // Level the board puts on lines that nothing drives or pulls
    input  logic [47:0] board,
    output logic [47:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] SHARED = 48'h0000_2a40_0000;
    logic shared_lvl;
    // Lines D1, C6, D3, D5 share one pin: a driver wins, else a pull-up
    always_comb
    begin
        pad_in = (pad_out & ~pad_oe_b) | (pad_oe_b & (pad_pu | board));
        shared_lvl = (|(pad_pu & SHARED)) ? 1'b1 : board[25];
        for (int i = 0; i < 48; i++)
            if (SHARED[i] && !pad_oe_b[i])
                shared_lvl = pad_out[i];
        for (int i = 0; i < 48; i++)
            if (SHARED[i])
                pad_in[i] = shared_lvl;
    end
endmodule // gpbr_pins

// ---- tb/gpbr_bank_tb.sv ----
module gpbr_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst_b, wr_stb, rd_stb, halt_mode, wake_req;
    logic        spi_en, spi_mosi, tim_en, tim_ch1;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, wake_src;
    logic [47:0] pad_in, pad_out, pad_oe_b, pad_pu, board;
    int          fail_count, num_checks, p;

    gpbr_bank #(.NPORT(6)) gpbr_bank_inst (.CORE_CLK(core_clk), .RST_B(rst_b), .ADDR(addr),
        .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .HALT_MODE(halt_mode), .WAKE_REQ(wake_req), .WAKE_SRC_A(wake_src), .SPI_EN(spi_en),
        .SPI_MOSI(spi_mosi), .TIM1_EN(tim_en), .ADVANCED_TIMER_CHANNEL_ONE(tim_ch1), .PAD_IN(pad_in),
        .PAD_OUT(pad_out), .PAD_OE_B(pad_oe_b), .PAD_PU(pad_pu));
    gpbr_pins gpbr_pins_inst (.pad_out(pad_out), .pad_oe_b(pad_oe_b), .pad_pu(pad_pu),
        .board(board), .pad_in(pad_in));

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    function automatic logic [15:0] ra(int port, int ofs);
        return 16'h5000 + 16'(5 * port + ofs);
    endfunction
    task automatic check(logic [47:0] got, logic [47:0] exp, string what);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge core_clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask
    // Read data is looked at only in the cycle after the strobe
    task automatic rd(logic [15:0] a, logic [7:0] exp, string what);
        @(posedge core_clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1 check(rdata, exp, what);
    endtask
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // A hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        {rst_b, wr_stb, rd_stb, halt_mode, spi_en, spi_mosi, tim_en, tim_ch1} = '0;
        {addr, wdata, wake_src, board} = '0;
        repeat (20) @(posedge core_clk);
        check(pad_pu, 48'h0000_0200_0000, "pull-up in reset");
        rst_b <= 1'b1;
        #1 check(pad_oe_b, 48'hffff_ffff_ffff, "released lines");
        for (p = 0; p < 6; p++)
        begin
            rd(ra(p, 0), 8'h00, "latch reset");
            rd(ra(p, 2), 8'h00, "dir reset");
            rd(ra(p, 3), (p == 3) ? 8'h02 : 8'h00, "ctl1 reset");
            wr(ra(p, 4), 8'ha5 ^ 8'(p));
            rd(ra(p, 4), 8'ha5 ^ 8'(p), "ctl2 readback");
        end
        rd(16'h6000, 8'h00, "unmapped read");
        wr(ra(1, 2), 8'hff);
        wr(ra(1, 3), 8'hff);
        $display("register test done");
        // Port A push-pull, then open drain
        wr(ra(0, 3), 8'hff);
        wr(ra(0, 2), 8'hff);
        wr(ra(0, 0), 8'h5a);
        settle();
        check(pad_out[7:0], 8'h5a, "push-pull value");
        check(pad_oe_b[7:0], 8'h00, "push-pull enable");
        rd(ra(0, 1), 8'h5a, "pin value");
        wr(ra(0, 3), 8'h00);
        settle();
        check(pad_oe_b[7:0], 8'h5a, "open-drain enable");
        $display("output test done");
        // Drive line A1 high push-pull so the halt release is visible
        wr(ra(0, 3), 8'hff);
        @(posedge core_clk);
        halt_mode <= 1'b1;
        wake_src <= 8'h02;
        repeat (3) @(posedge core_clk);
        #1 check({pad_oe_b[1], pad_pu[1]}, 2'b11, "halt line A1");
        check(wake_req, 1'b0, "halt wake");
        @(posedge core_clk);
        halt_mode <= 1'b0;
        settle();
        check(wake_req, 1'b1, "run wake");
        check(pad_oe_b[1], 1'b0, "drive after halt");
        check(pad_out[7:0], 8'h5a, "value after halt");
        $display("halt test done");
        // Line C6 push-pull with peripherals on, latch low
        wr(ra(2, 2), 8'h40);
        wr(ra(2, 3), 8'h40);
        {spi_en, spi_mosi, tim_en} <= 3'b111;
        settle();
        check(pad_out[22], 1'b1, "default function");
        wr(16'h501e, 8'h01);
        settle();
        check(pad_out[22], 1'b0, "default disconnected");
        @(posedge core_clk);
        tim_ch1 <= 1'b1;
        settle();
        check(pad_out[22], 1'b1, "remapped function");
        @(posedge core_clk);
        tim_en <= 1'b0;
        settle();
        check(pad_out[22], 1'b0, "latch without enable");
        rd(16'h501e, 8'h01, "remap readback");
        $display("remap test done");
        report_and_stop();
    end
endmodule // gpbr_bank_tb
